// file: e1_bert_map.svh
// Register indices, field positions, reset values and counts for the pattern test block.
`ifndef E1_BERT_MAP_SVH
`define E1_BERT_MAP_SVH

// Register indices; the byte address is four times the index.
`define IDX_PATTERN_CTRL 10'h123
`define IDX_LOOP_CTRL 10'h124
`define IDX_TX_LOOP 10'h125
`define IDX_RX_LOOP_ACT 10'h126
`define IDX_RX_LOOP_DEACT 10'h127
`define IDX_DEFECT 10'h129
`define IDX_SA_SOURCE 10'h130
`define IDX_SA_HOLD_BASE 10'h133
`define IDX_SA_HOLD_LAST 10'h137

// Field positions in the pattern control and status register.
`define PT_KIND 7
`define PT_INJECT 6
`define PT_INVERT 5
`define PT_LOCK 4
`define PT_DETECT 3
`define PT_GEN 2
`define PT_RX_SKIP 1
`define PT_TX_SKIP 0

// Field positions in the defect and national bit source registers.
`define DEFECT_BIT 7
`define SA_SEL_LSB 3
`define SA_COUNT 5

// Reset values.
`define PT_RESET 8'h00
`define DEFECT_RESET 1'h1
`define SA_RESET 8'h00
`define LFSR_SEED 20'h00001

// Detector and generator counts.
`define LOCK_MATCHES 6'h20
`define LOSS_MISSES 3'h4
`define QRTS_ZERO_LIMIT 4'hE

// Bus response codes.
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// file: e1_bert_pkg.sv
// Types shared by the pattern test register block and its pattern engine.
package e1_bert_pkg;

    // One serial bit with its bit strobe.
    typedef struct packed {
        logic data;
        logic strobe;
    } serial_s;

    // Control bits of the pattern control and status register.
    typedef struct packed {
        logic kind;
        logic inject;
        logic invert;
        logic det_on;
        logic gen_on;
        logic rx_skip;
        logic tx_skip;
    } pattern_ctrl_s;

    // State of the pattern engine.
    typedef struct packed {
        logic [19:0] gen_lfsr;
        logic [3:0] gen_zeros;
        logic inj_pend;
        logic [19:0] det_lfsr;
        logic [3:0] det_zeros;
        logic [5:0] match_cnt;
        logic [2:0] miss_cnt;
        logic lock;
    } engine_s;

    // State of the register block.
    typedef struct packed {
        pattern_ctrl_s ctrl;
        logic inj_prev;
        logic defect_on;
        logic [4:0] sa_src;
        logic [4:0] sa_live;
        logic [4:0][7:0] sa_hold;
        logic [2:0] sa_frame;
        logic aw_have;
        logic [9:0] aw_idx;
        logic w_have;
        logic [7:0] w_data;
        logic w_lane;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [7:0] rdata;
        logic [1:0] rresp;
        serial_s tx_out;
        serial_s rx_out;
    } block_s;

endpackage : e1_bert_pkg

// file: pattern_engine.sv
// Test pattern generator and lock detector for the 15-stage and quasi-random patterns.
`include "e1_bert_map.svh"

module pattern_engine (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic kind,
    input wire logic invert,
    input wire logic gen_step,
    input wire logic inject_pulse,
    input wire logic det_on,
    input wire e1_bert_pkg::serial_s det_in,
    output logic gen_bit,
    output logic lock
);

    e1_bert_pkg::engine_s s_r;
    e1_bert_pkg::engine_s s_nxt;
    logic g_raw;
    logic g_out;
    logic d_raw;
    logic d_exp;
    logic d_bit;

    // Feedback taps: x^15+x^14+1, or x^20+x^17+1 for the quasi-random signal.
    assign g_raw = kind ? (s_r.gen_lfsr[19] ^ s_r.gen_lfsr[16]) :
        (s_r.gen_lfsr[14] ^ s_r.gen_lfsr[13]);
    assign d_raw = kind ? (s_r.det_lfsr[19] ^ s_r.det_lfsr[16]) :
        (s_r.det_lfsr[14] ^ s_r.det_lfsr[13]);
    // The quasi-random signal forces a one after a long run of zeros.
    assign g_out = g_raw | (kind & (s_r.gen_zeros >= `QRTS_ZERO_LIMIT));
    assign d_exp = d_raw | (kind & (s_r.det_zeros >= `QRTS_ZERO_LIMIT));
    assign d_bit = det_in.data ^ invert;
    // A pending error flips exactly one emitted bit.
    assign gen_bit = g_out ^ s_r.inj_pend ^ invert;
    assign lock = s_r.lock;

    // Next state of generator and detector.
    always_comb begin
        s_nxt = s_r;
        if (gen_step) begin
            s_nxt.gen_lfsr = {s_r.gen_lfsr[18:0], g_raw};
            s_nxt.gen_zeros = g_out ? 4'h0 :
                (s_r.gen_zeros == 4'hF ? s_r.gen_zeros : s_r.gen_zeros + 4'h1);
            s_nxt.inj_pend = 1'b0;
        end
        // A new error request wins over the clear by the step.
        if (inject_pulse) begin
            s_nxt.inj_pend = 1'b1;
        end
        if (!det_on) begin
            s_nxt.lock = 1'b0;
            s_nxt.match_cnt = 6'h00;
            s_nxt.miss_cnt = 3'h0;
        end else if (det_in.strobe) begin
            s_nxt.det_zeros = d_exp ? 4'h0 :
                (s_r.det_zeros == 4'hF ? s_r.det_zeros : s_r.det_zeros + 4'h1);
            if (!s_r.lock) begin
                // Hunting: load received bits and count clean predictions.
                s_nxt.det_lfsr = {s_r.det_lfsr[18:0], d_bit};
                if (d_bit == d_exp && (|s_r.det_lfsr)) begin
                    s_nxt.match_cnt = s_r.match_cnt + 6'h01;
                    if (s_nxt.match_cnt == `LOCK_MATCHES) begin
                        s_nxt.lock = 1'b1;
                        s_nxt.miss_cnt = 3'h0;
                    end
                end else begin
                    s_nxt.match_cnt = 6'h00;
                end
            end else begin
                // Locked: run free and drop lock after a burst of misses.
                s_nxt.det_lfsr = {s_r.det_lfsr[18:0], d_raw};
                if (d_bit != d_exp) begin
                    s_nxt.miss_cnt = s_r.miss_cnt + 3'h1;
                    if (s_nxt.miss_cnt == `LOSS_MISSES) begin
                        s_nxt.lock = 1'b0;
                        s_nxt.match_cnt = 6'h00;
                    end
                end else begin
                    s_nxt.miss_cnt = 3'h0;
                end
            end
        end
    end

    // State register with synchronous reset.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_r <= '0;
            s_r.gen_lfsr <= `LFSR_SEED;
        end else begin
            s_r <= s_nxt;
        end
    end

endmodule : pattern_engine

// file: e1_bert_bypass_sa_select.sv
// Per-channel E1 pattern test, framer bypass and national bit source register block.
// Behaviour
// - A read-only lock bit reports the active detector's lock, per routing.
// - Lock reads 1 when synchronised, 0 otherwise, and resets to 0.
// - Switch off with detect on: line receive data is checked.
// - Switch on with detect on: transmit backplane data is checked.
// - Detect enable turns detection off at 0, on at 1; resets to 0.
// - Switch off with generator on: pattern goes toward the line.
// - Switch on with generator on: pattern replaces receive backplane data.
// - Receive bypass at 1 routes receive data around receive framing.
// - Transmit bypass at bit 0 skips transmit framing; resets to 0.
// - Sa8 comes from serial input at 0, holding register at 1.
// - Sa7 comes from serial input at 0, holding register at 1.
// - Sa6 comes from serial input at 0, holding register at 1.
// - Sa5 comes from serial input at 0, holding register at 1.
// - Sa4 comes from serial input at 0, holding register at 1.
// - Pattern kind picks x^15+x^14+1 at 0, quasi-random at 1.
// - A rising error control inverts one generated bit while generating.
// - Invert at 1 flips generated output and detector input data.
//
// The AXI4-Lite interface to the registers and the address map were decided locally.
`include "e1_bert_map.svh"

module e1_bert_bypass_sa_select (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic bert_switch,
    input wire e1_bert_pkg::serial_s line_rx,
    input wire e1_bert_pkg::serial_s tx_serial_in,
    input wire logic tx_frame_start,
    input wire logic [4:0] tx_sa_slot,
    output e1_bert_pkg::serial_s tx_line,
    output e1_bert_pkg::serial_s rx_backplane,
    output logic tx_framing_skip,
    output logic rx_framing_skip,
    output logic defect_check_on
);

    e1_bert_pkg::block_s s_r;
    e1_bert_pkg::block_s s_nxt;
    e1_bert_pkg::serial_s det_in;
    logic gen_step;
    logic gen_bit;
    logic pattern_lock_flag;
    logic inject_pulse;
    logic [4:0] sa_pick;
    logic [9:0] ar_idx;
    logic [7:0] rd_byte;
    logic rd_hit;

    // The detector watches the side chosen by the routing switch.
    assign det_in = bert_switch ? tx_serial_in : line_rx;
    // The generator steps on the bit strobe of the side that it drives.
    assign gen_step = s_r.ctrl.gen_on &
        (bert_switch ? line_rx.strobe : tx_serial_in.strobe);
    // Only a 0 to 1 change while generating asks for an error.
    assign inject_pulse = s_r.ctrl.inject & ~s_r.inj_prev & s_r.ctrl.gen_on;

    pattern_engine u_pattern_engine (
        .aclk(aclk),
        .aresetn(aresetn),
        .kind(s_r.ctrl.kind),
        .invert(s_r.ctrl.invert),
        .gen_step(gen_step),
        .inject_pulse(inject_pulse),
        .det_on(s_r.ctrl.det_on),
        .det_in(det_in),
        .gen_bit(gen_bit),
        .lock(pattern_lock_flag)
    );

    // Holding register bit for each Sa position, picked by frame count.
    generate
        for (genvar i = 0; i < `SA_COUNT; i++) begin : g_sa
            assign sa_pick[i] = s_r.sa_hold[i][s_r.sa_frame];
        end
    endgenerate

    // Read data for the read index on the address bus, taken straight from s_axi_araddr.
    assign ar_idx = s_axi_araddr[11:2];
    always_comb begin
        rd_byte = 8'h00;
        rd_hit = 1'b1;
        case (ar_idx)
            `IDX_PATTERN_CTRL: begin
                rd_byte[`PT_KIND] = s_r.ctrl.kind;
                rd_byte[`PT_INJECT] = s_r.ctrl.inject;
                rd_byte[`PT_INVERT] = s_r.ctrl.invert;
                rd_byte[`PT_LOCK] = pattern_lock_flag;
                rd_byte[`PT_DETECT] = s_r.ctrl.det_on;
                rd_byte[`PT_GEN] = s_r.ctrl.gen_on;
                rd_byte[`PT_RX_SKIP] = s_r.ctrl.rx_skip;
                rd_byte[`PT_TX_SKIP] = s_r.ctrl.tx_skip;
            end
            `IDX_LOOP_CTRL, `IDX_TX_LOOP, `IDX_RX_LOOP_ACT, `IDX_RX_LOOP_DEACT: begin
                rd_byte = 8'h00;
            end
            `IDX_DEFECT: begin
                rd_byte[`DEFECT_BIT] = s_r.defect_on;
            end
            `IDX_SA_SOURCE: begin
                rd_byte[`SA_SEL_LSB +: `SA_COUNT] = s_r.sa_src;
            end
            default: begin
                if (ar_idx >= `IDX_SA_HOLD_BASE && ar_idx <= `IDX_SA_HOLD_LAST) begin
                    rd_byte = s_r.sa_hold[3'(ar_idx - `IDX_SA_HOLD_BASE)];
                end else begin
                    rd_hit = 1'b0;
                end
            end
        endcase
    end

    // Next state: bus slave, register writes and the two data paths.
    always_comb begin
        s_nxt = s_r;
        s_nxt.inj_prev = s_r.ctrl.inject;

        // Write address and data are taken independently.
        if (s_axi_awvalid && s_axi_awready) begin
            s_nxt.aw_have = 1'b1;
            s_nxt.aw_idx = s_axi_awaddr[11:2];
        end
        if (s_axi_wvalid && s_axi_wready) begin
            s_nxt.w_have = 1'b1;
            s_nxt.w_data = s_axi_wdata[7:0];
            s_nxt.w_lane = s_axi_wstrb[0];
        end

        // Both halves present: update the register and raise the response.
        if (s_r.aw_have && s_r.w_have && !s_r.bvalid) begin
            s_nxt.aw_have = 1'b0;
            s_nxt.w_have = 1'b0;
            s_nxt.bvalid = 1'b1;
            s_nxt.bresp = `RESP_OKAY;
            case (s_r.aw_idx)
                `IDX_PATTERN_CTRL: begin
                    if (s_r.w_lane) begin
                        s_nxt.ctrl.kind = s_r.w_data[`PT_KIND];
                        s_nxt.ctrl.inject = s_r.w_data[`PT_INJECT];
                        s_nxt.ctrl.invert = s_r.w_data[`PT_INVERT];
                        s_nxt.ctrl.det_on = s_r.w_data[`PT_DETECT];
                        s_nxt.ctrl.gen_on = s_r.w_data[`PT_GEN];
                        s_nxt.ctrl.rx_skip = s_r.w_data[`PT_RX_SKIP];
                        s_nxt.ctrl.tx_skip = s_r.w_data[`PT_TX_SKIP];
                    end
                end
                `IDX_LOOP_CTRL, `IDX_TX_LOOP, `IDX_RX_LOOP_ACT, `IDX_RX_LOOP_DEACT: begin
                    s_nxt.bresp = `RESP_OKAY;
                end
                `IDX_DEFECT: begin
                    if (s_r.w_lane) begin
                        s_nxt.defect_on = s_r.w_data[`DEFECT_BIT];
                    end
                end
                `IDX_SA_SOURCE: begin
                    if (s_r.w_lane) begin
                        s_nxt.sa_src = s_r.w_data[`SA_SEL_LSB +: `SA_COUNT];
                    end
                end
                default: begin
                    if (s_r.aw_idx >= `IDX_SA_HOLD_BASE && s_r.aw_idx <= `IDX_SA_HOLD_LAST) begin
                        if (s_r.w_lane) begin
                            s_nxt.sa_hold[3'(s_r.aw_idx - `IDX_SA_HOLD_BASE)] = s_r.w_data;
                        end
                    end else begin
                        s_nxt.bresp = `RESP_SLVERR;
                    end
                end
            endcase
        end else if (s_r.bvalid && s_axi_bready) begin
            s_nxt.bvalid = 1'b0;
        end

        // Reads answer on the edge after the address is taken.
        if (s_axi_arvalid && s_axi_arready) begin
            s_nxt.rvalid = 1'b1;
            s_nxt.rdata = rd_byte;
            s_nxt.rresp = rd_hit ? `RESP_OKAY : `RESP_SLVERR;
        end else if (s_r.rvalid && s_axi_rready) begin
            s_nxt.rvalid = 1'b0;
        end

        // Source selects are sampled only at a frame boundary.
        if (tx_frame_start) begin
            s_nxt.sa_live = s_r.sa_src;
            s_nxt.sa_frame = s_r.sa_frame + 3'h1;
        end

        // Transmit path toward the line.
        s_nxt.tx_out.strobe = tx_serial_in.strobe;
        s_nxt.tx_out.data = tx_serial_in.data;
        if (!s_r.ctrl.tx_skip) begin
            // With framing bypassed no national bit is overwritten.
            for (int i = 0; i < `SA_COUNT; i++) begin
                if (tx_sa_slot[i] && s_r.sa_live[i]) begin
                    s_nxt.tx_out.data = sa_pick[i];
                end
            end
        end
        if (!bert_switch && s_r.ctrl.gen_on) begin
            s_nxt.tx_out.data = gen_bit;
        end

        // Receive path toward the backplane.
        s_nxt.rx_out.strobe = line_rx.strobe;
        s_nxt.rx_out.data = line_rx.data;
        if (bert_switch && s_r.ctrl.gen_on) begin
            s_nxt.rx_out.data = gen_bit;
        end
    end

    // State register with synchronous reset.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_r <= '0;
            s_r.ctrl <= e1_bert_pkg::pattern_ctrl_s'(7'(`PT_RESET));
            s_r.defect_on <= `DEFECT_RESET;
            s_r.sa_src <= 5'(`SA_RESET >> `SA_SEL_LSB);
        end else begin
            s_r <= s_nxt;
        end
    end

    // Bus handshakes and registered data outputs.
    assign s_axi_awready = ~s_r.aw_have & ~s_r.bvalid;
    assign s_axi_wready = ~s_r.w_have & ~s_r.bvalid;
    assign s_axi_bvalid = s_r.bvalid;
    assign s_axi_bresp = s_r.bresp;
    assign s_axi_arready = ~s_r.rvalid;
    assign s_axi_rvalid = s_r.rvalid;
    assign s_axi_rdata = {24'h000000, s_r.rdata};
    assign s_axi_rresp = s_r.rresp;
    assign tx_line = s_r.tx_out;
    assign rx_backplane = s_r.rx_out;
    assign tx_framing_skip = s_r.ctrl.tx_skip;
    assign rx_framing_skip = s_r.ctrl.rx_skip;
    assign defect_check_on = s_r.defect_on;

endmodule : e1_bert_bypass_sa_select

// file: e1_bert_assertions.sv
// Port checker for the pattern test register block, bound to its top module.
module e1_bert_assertions (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic bert_switch,
    input wire e1_bert_pkg::serial_s line_rx,
    input wire e1_bert_pkg::serial_s rx_backplane,
    input wire logic tx_framing_skip,
    input wire logic rx_framing_skip,
    input wire logic defect_check_on
);
    // All checks run on the bus clock and rest while reset is low.
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    reset_values_a: assert property ($rose(aresetn) |-> defect_check_on &&
        !tx_framing_skip && !rx_framing_skip && !s_axi_bvalid && !s_axi_rvalid)
        else $error("outputs wrong after reset");
    bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped early");
    rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped early");
    ar_refuse_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address taken while answering");
    aw_refuse_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while answering");
    read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
        s_axi_wready |-> ##[1:2] s_axi_bvalid) else $error("write answer late");
    rx_pass_a: assert property (line_rx.strobe && !bert_switch |=>
        rx_backplane.strobe && rx_backplane.data == $past(line_rx.data))
        else $error("receive data not passed through");
    cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
    cover property (bert_switch && rx_backplane.strobe);
    cover property ($rose(tx_framing_skip));
endmodule : e1_bert_assertions

bind e1_bert_bypass_sa_select e1_bert_assertions u_e1_bert_assertions (.*);

// file: e1_line_partner.sv
// Line interface and backplane model: bit strobes, frame marks, loopback or random data.
module e1_line_partner (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic line_loop,
    input wire logic bp_loop,
    input wire e1_bert_pkg::serial_s tx_line,
    input wire e1_bert_pkg::serial_s rx_backplane,
    output e1_bert_pkg::serial_s line_rx = '0,
    output e1_bert_pkg::serial_s tx_serial_in = '0,
    output logic tx_frame_start = 1'b0,
    output logic [4:0] tx_sa_slot = 5'h00
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] phase = 2'h0;
    logic [2:0] bit_num = 3'h0;
    logic line_bit = 1'b0;
    logic bp_bit = 1'b0;
    logic strobe;
    assign strobe = (phase == 2'h3);
    // One bit in four cycles, eight bits a frame; data toggles between bits so nothing lingers.
    always @(posedge aclk) begin
        if (!aresetn) begin
            phase <= 2'h0;
            bit_num <= 3'h0;
        end else begin
            phase <= phase + 2'h1;
            if (strobe) bit_num <= bit_num + 3'h1;
        end
        if (tx_line.strobe) line_bit <= tx_line.data;
        if (rx_backplane.strobe) bp_bit <= rx_backplane.data;
        line_rx <= strobe ? {line_loop ? line_bit : 1'($urandom), 1'b1} : {~line_rx.data, 1'b0};
        tx_serial_in <= strobe ? {bp_loop ? bp_bit : 1'($urandom), 1'b1} :
            {~tx_serial_in.data, 1'b0};
        tx_frame_start <= strobe && bit_num == 3'h0;
        tx_sa_slot <= (strobe && bit_num >= 3'h3) ? 5'(1 << (bit_num - 3'h3)) : 5'h00;
    end
endmodule : e1_line_partner

// file: test_e1_bert_bypass_sa_select.sv
// Self-checking bench for the pattern test, bypass and national bit source block.
`define check(got, exp) begin samples_checked++; if ((got) !== (exp)) begin mismatches++; \
    $display("mismatch at %0t got %h exp %h", $time, got, exp); end end
module test_e1_bert_bypass_sa_select;
    timeunit 1ns;
    timeprecision 1ps;
    logic aclk = 1'b0, aresetn = 1'b0, bert_switch = 1'b0, line_loop = 1'b0, bp_loop = 1'b0;
    logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic tx_frame_start, tx_framing_skip, rx_framing_skip, defect_check_on, gb, exp_tx;
    logic [4:0] tx_sa_slot;
    e1_bert_pkg::serial_s line_rx, tx_serial_in, tx_line, rx_backplane;
    logic [7:0] ctrl_m = 8'h00, defect_m = 8'h80, src_m = 8'h00, live_m = 8'h00;
    logic [7:0] hold_m [5] = '{default: 8'h00};
    logic [9:0] idx [13] = '{10'h123, 10'h124, 10'h125, 10'h126, 10'h127, 10'h129, 10'h130,
        10'h133, 10'h134, 10'h135, 10'h136, 10'h137, 10'h1FF};
    logic q[$];
    bit pend = 1'b0, sa_chk = 1'b0, gen_chk = 1'b0;
    int mismatches = 0, samples_checked = 0, viol = 0, k, i;
    logic [31:0] d;

    e1_bert_bypass_sa_select u_e1_bert_bypass_sa_select (.*);
    e1_line_partner u_e1_line_partner (.*);

    always #2.5 aclk = ~aclk;

    // Register model: reads, response codes and write effects.
    function automatic logic [7:0] model_rd(input logic [9:0] a);
        if (a >= 10'h133 && a <= 10'h137) return hold_m[a - 10'h133];
        return (a == 10'h123) ? ctrl_m : (a == 10'h129) ? defect_m : (a == 10'h130) ? src_m : 0;
    endfunction : model_rd
    function automatic logic [1:0] exp_resp(input logic [9:0] a);
        return (a inside {[10'h123:10'h127], 10'h129, 10'h130, [10'h133:10'h137]}) ? 0 : 2;
    endfunction : exp_resp
    task automatic model_wr(input logic [9:0] a, input logic [7:0] v);
        if (a >= 10'h133 && a <= 10'h137) hold_m[a - 10'h133] = v;
        if (a == 10'h123) ctrl_m = v & 8'hEF;
        if (a == 10'h129) defect_m = v & 8'h80;
        if (a == 10'h130) src_m = v & 8'hF8;
    endtask : model_wr

    // Bus write and read; ready of the answer is sometimes late to exercise the hold.
    task automatic wr(input logic [9:0] a, input logic [7:0] v);
        @(posedge aclk);
        s_axi_awaddr <= {a, 2'h0};
        s_axi_wdata <= {24'h0, v};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'($urandom);
        while (!(s_axi_bvalid && s_axi_bready)) begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (!s_axi_bready) s_axi_bready <= 1'b1;
        end
        s_axi_bready <= 1'b0;
        `check(s_axi_bresp, exp_resp(a))
        if (exp_resp(a) == 0 && s_axi_wstrb[0]) model_wr(a, v);
    endtask : wr
    task automatic rd(input logic [9:0] a, output logic [31:0] v);
        @(posedge aclk);
        s_axi_araddr <= {a, 2'h0};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'($urandom);
        while (!(s_axi_rvalid && s_axi_rready)) begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (!s_axi_rready) s_axi_rready <= 1'b1;
        end
        s_axi_rready <= 1'b0;
        v = s_axi_rdata;
        `check(s_axi_rresp, exp_resp(a))
        `check(v & ((a == 10'h123) ? 32'hFFFFFFEF : 32'hFFFFFFFF), {24'h0, model_rd(a)})
    endtask : rd
    task automatic poll(input logic want);
        logic [31:0] v;
        int n;
        v = want ? 32'h0 : 32'h10;
        for (n = 0; n < 400 && v[4] !== want; n++) rd(10'h123, v);
        `check(v[4], want)
    endtask : poll

    // Monitor: national bit insertion on the line and the recurrence of the generated stream.
    always @(posedge aclk) begin
        if (pend) `check(tx_line.data, exp_tx)
        if (tx_frame_start) live_m = src_m;
        exp_tx = tx_serial_in.data;
        for (int j = 0; j < 5; j++) if (tx_sa_slot[j] && live_m[3 + j] && !ctrl_m[0])
            exp_tx = hold_m[j][0];
        pend = sa_chk && tx_serial_in.strobe;
        gb = bert_switch ? rx_backplane.data : tx_line.data;
        if (gen_chk && (bert_switch ? rx_backplane.strobe : tx_line.strobe)) begin
            if (q.size() >= 15 && (gb ^ q[$ - 13] ^ q[$ - 14]) != ctrl_m[5]) viol++;
            q.push_back(gb);
        end
        if (!gen_chk) q.delete();
    end

    task automatic conclude();
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : conclude

    // Watchdog against a hang.
    initial begin
        #150000;
        mismatches++;
        conclude();
    end

    // Main sequence: reset values, register access, national bits, pattern lock.
    initial begin
        void'($urandom(32'h92cc));
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        foreach (idx[j]) rd(idx[j], d);
        s_axi_wstrb <= 4'h0;
        wr(10'h123, 8'hFF);
        s_axi_wstrb <= 4'hF;
        foreach (idx[j]) wr(idx[j], 8'($urandom));
        foreach (idx[j]) rd(idx[j], d);
        `check(tx_framing_skip, ctrl_m[0])
        `check(rx_framing_skip, ctrl_m[1])
        `check(defect_check_on, defect_m[7])
        wr(10'h129, 8'h80);
        wr(10'h123, 8'h00);
        for (k = 0; k < 4; k++) begin
            sa_chk = 1'b0;
            for (i = 0; i < 5; i++) wr(10'h133 + 10'(i), {8{1'($urandom)}});
            @(posedge tx_frame_start);
            wr(10'h130, 8'($urandom) & 8'hF8);
            if (k == 3) wr(10'h123, 8'h01);
            sa_chk = 1'b1;
            repeat (70) @(posedge aclk);
        end
        sa_chk = 1'b0;
        wr(10'h130, 8'h00);
        for (k = 0; k < 8; k++) begin
            gen_chk = 1'b0;
            bert_switch <= k[0];
            line_loop <= !k[0];
            bp_loop <= k[0];
            wr(10'h123, {k[1], 1'b0, k[2], 5'h0C});
            repeat (8) @(posedge aclk);
            viol = 0;
            gen_chk = !k[1];
            poll(1'b1);
            `check(viol, 0)
            if (k == 0) begin
                wr(10'h123, 8'h4C);
                repeat (100) @(posedge aclk);
                `check(viol, 3)
            end
            line_loop <= k[0];
            bp_loop <= !k[0];
            poll(1'b0);
            wr(10'h123, 8'h04);
            poll(1'b0);
        end
        conclude();
    end
endmodule : test_e1_bert_bypass_sa_select
